// file: src/gptmr_top.sv
/*
 * Dual 16-bit / cascaded 32-bit general purpose timer pair with gated
 * accumulation, prescalers, period match trigger and upper timer flag.
 * Assumes one 100 MHz clock (each rising edge is one instruction cycle), a
 * register port with read data one cycle after the read strobe, and that
 * the gate/clock pin and sleep level arrive asynchronously.
 */
`timescale 1ns/1ps

module gptmr_top
  import gptmr_pkg::*;
(
  input wire logic clock_i, // 100 MHz instruction clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire gptmr_req_t req_i, // Register port request
  input wire logic gate_clock_input_pin_i, // Gate or external clock pin
  input wire logic sleep_i, // Processor sleep level
  output logic [DATA_W-1:0] rdata_o, // Read data, cycle after strobe
  output logic adc_trigger_o, // One-cycle ADC trigger pulse
  output logic irq_o // Interrupt request level
);

  // Terminal count of the prescaler for a select code
  function automatic logic [7:0] ps_last(input logic [1:0] sel);
    case (gptmr_ps_t'(sel))
      GPTMR_DIV1: ps_last = PS_LAST_1;
      GPTMR_DIV8: ps_last = PS_LAST_8;
      GPTMR_DIV64: ps_last = PS_LAST_64;
      default: ps_last = PS_LAST_256;
    endcase
  endfunction : ps_last

  logic [15:0] low_count_q, high_count_q, hold_q;
  logic [15:0] low_period_q, high_period_q;
  logic [15:0] low_ctrl_q, high_ctrl_q;
  logic [7:0] low_ps_q, high_ps_q;
  logic flag_q, irq_en_q;
  logic pin_s1_q, pin_s2_q, pin_d_q, sleep_s1_q, sleep_s2_q;

  // Two-stage synchronisers for the pin and the sleep level
  // Trade-off: the pin reaches the counters two cycles late, and a
  // gate or clock pulse shorter than one clock cycle may be missed
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_d_q <= 1'b0;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= gate_clock_input_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_d_q <= pin_s2_q;
      sleep_s1_q <= sleep_i;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // Decodes; offsets must match exactly, so odd addresses and the gaps
  // between registers never reach a register
  logic wr, rd;
  assign wr = req_i.wr;
  assign rd = req_i.rd;
  logic wr_lc, wr_hc, wr_hold, wr_lcnt, wr_hcnt;
  assign wr_lc = wr && req_i.addr == OFF_LOW_CTRL;
  assign wr_hc = wr && req_i.addr == OFF_HIGH_CTRL;
  assign wr_hold = wr && req_i.addr == OFF_HOLD;
  assign wr_lcnt = wr && req_i.addr == OFF_LOW_COUNT;
  assign wr_hcnt = wr && req_i.addr == OFF_HIGH_COUNT;

  logic cascade;
  assign cascade = low_ctrl_q[BIT_CASCADE];

  // Lower timer configuration; in cascade it governs both words
  logic l_on, l_gate, l_ext;
  assign l_on = low_ctrl_q[BIT_TIMER_ON];
  // Lower gate enable taken from lower control, cascaded or not
  assign l_gate = low_ctrl_q[BIT_GATE_EN];
  assign l_ext = low_ctrl_q[BIT_CLK_SRC];
  // Upper control bits matter only when not cascaded
  logic h_on, h_gate, h_ext;
  assign h_on = high_ctrl_q[BIT_TIMER_ON] && !cascade;
  assign h_gate = high_ctrl_q[BIT_GATE_EN];
  assign h_ext = high_ctrl_q[BIT_CLK_SRC];

  // Input clock events: pin rising edge or every instruction cycle
  logic pin_rise, pin_fall;
  assign pin_rise = pin_s2_q && !pin_d_q;
  assign pin_fall = !pin_s2_q && pin_d_q;

  // Gated: count cycles only while the pin is high
  // Sleep stops every clock tick
  // External source takes precedence, so gate enable means nothing then
  logic l_tick_in, h_tick_in;
  always_comb begin
    if (l_ext)
      l_tick_in = pin_rise;
    else if (l_gate)
      l_tick_in = pin_s2_q;
    else
      l_tick_in = 1'b1;
    l_tick_in = l_tick_in && l_on && !sleep_s2_q;
    if (h_ext)
      h_tick_in = pin_rise;
    else if (h_gate)
      h_tick_in = pin_s2_q;
    else
      h_tick_in = 1'b1;
    h_tick_in = h_tick_in && h_on && !sleep_s2_q;
  end

  // Prescaler outputs
  logic l_ps_tc, h_ps_tc;
  assign l_ps_tc = low_ps_q == ps_last(low_ctrl_q[BIT_PS_HI:BIT_PS_LO]);
  assign h_ps_tc = high_ps_q == ps_last(high_ctrl_q[BIT_PS_HI:BIT_PS_LO]);
  logic l_inc, h_inc;
  assign l_inc = l_tick_in && l_ps_tc;
  assign h_inc = h_tick_in && h_ps_tc;

  // Lower prescaler clears on count or control writes and reset
  // Halted while off, so a clear then does not reach it
  // The clear outranks the tick, or a write landing mid-division would leave
  // the prescaler part way through and bring the next count early
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      low_ps_q <= 8'h00;
    else if (l_on && (wr_lc || wr_lcnt || (cascade && wr_hcnt)))
      low_ps_q <= 8'h00;
    else if (l_tick_in)
      low_ps_q <= l_ps_tc ? 8'h00 : low_ps_q + 8'h01;
  end

  // Upper prescaler idle in cascade; cleared on its count or control writes even while off
  // Held at zero in cascade, so leaving it starts a clean division
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      high_ps_q <= 8'h00;
    else if (cascade || wr_hc || wr_hcnt)
      high_ps_q <= 8'h00;
    else if (h_tick_in)
      high_ps_q <= h_ps_tc ? 8'h00 : high_ps_q + 8'h01;
  end

  // Period matches
  // The combined compare is always built; it is simply unused while the
  // two timers run apart
  logic match32, match_l, match_h;
  assign match32 = {high_count_q, low_count_q} ==
                   {high_period_q, low_period_q};
  assign match_l = low_count_q == low_period_q;
  assign match_h = high_count_q == high_period_q;

  // Count registers change only by counting or count writes
  // Lower word write loads the upper word from holding in cascade
  // Cascade wraps to zero after the combined period
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_count_q <= RST_COUNT;
    end else if (wr_lcnt) begin
      low_count_q <= req_i.wdata;
    end else if (l_inc) begin
      if (cascade ? match32 : match_l)
        low_count_q <= RST_COUNT;
      else
        low_count_q <= low_count_q + 16'h0001;
    end
  end

  // Upper word: loaded from holding, written, carried into, or counted
  // A holding load outranks a direct upper write in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      high_count_q <= RST_COUNT;
    end else if (cascade && wr_lcnt) begin
      high_count_q <= hold_q;
    end else if (wr_hcnt) begin
      high_count_q <= req_i.wdata;
    end else if (cascade) begin
      if (l_inc && match32)
        high_count_q <= RST_COUNT;
      else if (l_inc && &low_count_q)
        high_count_q <= high_count_q + 16'h0001;
    end else if (h_inc) begin
      high_count_q <= match_h ? RST_COUNT : high_count_q + 16'h0001;
    end
  end

  // Holding register; in cascade a lower read snapshots the upper word
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      hold_q <= RST_COUNT;
    else if (wr_hold)
      hold_q <= req_i.wdata;
    else if (cascade && rd && req_i.addr == OFF_LOW_COUNT)
      hold_q <= high_count_q;
  end

  // Period and control registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_period_q <= RST_PERIOD;
      high_period_q <= RST_PERIOD;
      low_ctrl_q <= RST_CTRL;
      high_ctrl_q <= RST_CTRL;
      irq_en_q <= 1'b0;
    end else begin
      if (wr && req_i.addr == OFF_LOW_PERIOD)
        low_period_q <= req_i.wdata;
      if (wr && req_i.addr == OFF_HIGH_PERIOD)
        high_period_q <= req_i.wdata;
      // Gate enable and other control bits stored here
      if (wr_lc)
        low_ctrl_q <= req_i.wdata & LOW_CTRL_MASK;
      if (wr_hc)
        high_ctrl_q <= req_i.wdata & HIGH_CTRL_MASK;
      if (wr && req_i.addr == OFF_IRQ_ENABLE)
        irq_en_q <= req_i.wdata[BIT_UPPER_IRQ];
    end
  end

  // Gate falling edge ends accumulation without touching the count
  logic gate_fall;
  assign gate_fall = l_gate && !l_ext && l_on && pin_fall &&
                     !sleep_s2_q;
  logic upper_match;
  assign upper_match = cascade ? (l_inc && match32) : (h_inc && match_h);

  // Set on match or gate fall; set wins over a clearing write
  // Only a software write or reset clears the flag
  // Limitation: a clear that meets a set event is lost; software should
  // read the status back after clearing
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      flag_q <= 1'b0;
    else if (upper_match || gate_fall)
      flag_q <= 1'b1;
    else if (wr && req_i.addr == OFF_IRQ_STATUS)
      flag_q <= req_i.wdata[BIT_UPPER_IRQ];
  end

  // Trigger pulse from the upper timer match
  // Request gated by the enable bit
  // Both are registered so they leave the block straight from flops; the
  // request therefore trails its setting event by one cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      adc_trigger_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      adc_trigger_o <= upper_match;
      irq_o <= (flag_q || upper_match || gate_fall) && irq_en_q;
    end
  end

  // Read data register; unmapped addresses read zero
  // Driving zero outside the reply cycle keeps a shared read bus quiet
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd) begin
      case (req_i.addr)
        OFF_LOW_COUNT: rdata_o <= low_count_q;
        OFF_HOLD: rdata_o <= hold_q;
        OFF_HIGH_COUNT: rdata_o <= high_count_q;
        OFF_LOW_PERIOD: rdata_o <= low_period_q;
        OFF_HIGH_PERIOD: rdata_o <= high_period_q;
        OFF_LOW_CTRL: rdata_o <= low_ctrl_q;
        OFF_HIGH_CTRL: rdata_o <= high_ctrl_q;
        OFF_IRQ_STATUS: rdata_o <= 16'(flag_q) << BIT_UPPER_IRQ;
        OFF_IRQ_ENABLE: rdata_o <= 16'(irq_en_q) << BIT_UPPER_IRQ;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule : gptmr_top

// file: pkg/gptmr_pkg.sv
/*
 * Package for the dual 16/32-bit general purpose timer pair: register
 * offsets, control field positions, reset values, prescale codes and the
 * register bus carrier.
 * Assumes a 16-bit register port with byte offsets as printed.
 */
package gptmr_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [15:0] OFF_LOW_COUNT = 16'h0106;
  localparam logic [15:0] OFF_HOLD = 16'h0108;
  localparam logic [15:0] OFF_HIGH_COUNT = 16'h010a;
  localparam logic [15:0] OFF_LOW_PERIOD = 16'h010c;
  localparam logic [15:0] OFF_HIGH_PERIOD = 16'h010e;
  localparam logic [15:0] OFF_LOW_CTRL = 16'h0110;
  localparam logic [15:0] OFF_HIGH_CTRL = 16'h0112;
  localparam logic [15:0] OFF_IRQ_STATUS = 16'h0114;
  localparam logic [15:0] OFF_IRQ_ENABLE = 16'h0116;

  // Control field positions
  localparam int unsigned BIT_TIMER_ON = 15;
  localparam int unsigned BIT_STOP_IN_IDLE = 13;
  localparam int unsigned BIT_GATE_EN = 6;
  localparam int unsigned BIT_PS_HI = 5;
  localparam int unsigned BIT_PS_LO = 4;
  localparam int unsigned BIT_CASCADE = 3;
  localparam int unsigned BIT_CLK_SRC = 1;
  localparam int unsigned BIT_UPPER_IRQ = 7;

  // Writable bits of each control register; the rest read as zero
  localparam logic [15:0] LOW_CTRL_MASK = 16'ha07a;
  localparam logic [15:0] HIGH_CTRL_MASK = 16'ha072;
  localparam logic [15:0] IRQ_MASK = 16'h0080;

  // Reset values
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // Prescale select codes and the prescaler terminal counts
  typedef enum logic [1:0] {
    GPTMR_DIV1 = 2'b00,
    GPTMR_DIV8 = 2'b01,
    GPTMR_DIV64 = 2'b10,
    GPTMR_DIV256 = 2'b11
  } gptmr_ps_t;

  localparam logic [7:0] PS_LAST_1 = 8'h00;
  localparam logic [7:0] PS_LAST_8 = 8'h07;
  localparam logic [7:0] PS_LAST_64 = 8'h3f;
  localparam logic [7:0] PS_LAST_256 = 8'hff;

  // Register bus request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gptmr_req_t;

endpackage : gptmr_pkg

// file: sim/gptmr_properties.sv
/* Checker for the timer pair port.
   Assumes the bench keeps strobes one cycle long. */
`timescale 1ns/1ps
module gptmr_chk
  import gptmr_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire gptmr_req_t req_i, // Request
  input wire logic gate_clock_input_pin_i, // Gate pin
  input wire logic sleep_i, // Sleep level
  input wire logic [DATA_W-1:0] rdata_o, // Read data
  input wire logic adc_trigger_o, // Trigger
  input wire logic irq_o // Interrupt
);
  logic en_q; // Shadow of the enable bit
  logic map_w; // Address is decoded
  // Shadow follows enable writes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else if (req_i.wr && req_i.addr == OFF_IRQ_ENABLE) begin
      en_q <= req_i.wdata[BIT_UPPER_IRQ];
    end
  end
  // Map is the even offsets of one span
  assign map_w = !req_i.addr[0] && req_i.addr >= OFF_LOW_COUNT &&
    req_i.addr <= OFF_IRQ_ENABLE;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle;
    !$past(req_i.rd) |-> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside reply");
  property p_unmap;
    req_i.rd && !map_w |=> rdata_o == '0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_lctrl;
    req_i.rd && req_i.addr == OFF_LOW_CTRL
      |=> (rdata_o & ~LOW_CTRL_MASK) == '0;
  endproperty
  a_lctrl: assert property (p_lctrl)
    else $error("low control spare bits set");
  property p_hctrl;
    req_i.rd && req_i.addr == OFF_HIGH_CTRL
      |=> (rdata_o & ~HIGH_CTRL_MASK) == '0;
  endproperty
  a_hctrl: assert property (p_hctrl)
    else $error("high control spare bits set");
  property p_irqst;
    req_i.rd && req_i.addr == OFF_IRQ_STATUS
      |=> (rdata_o & ~IRQ_MASK) == '0;
  endproperty
  a_irqst: assert property (p_irqst)
    else $error("status spare bits set");
  property p_hold;
    req_i.wr && req_i.addr == OFF_HOLD ##1 !req_i.wr && !req_i.rd ##1
      req_i.rd && req_i.addr == OFF_HOLD |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_hold: assert property (p_hold)
    else $error("holding word lost");
  property p_irq_en;
    irq_o |-> en_q || $past(en_q);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("request while disabled");
  property p_sleep;
    sleep_i [*8] |=> !adc_trigger_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("trigger during sleep");
endmodule : gptmr_chk

bind gptmr_top gptmr_chk i_gptmr_chk (.clock_i, .rst_i, .req_i,
  .gate_clock_input_pin_i, .sleep_i, .rdata_o, .adc_trigger_o, .irq_o);

// file: sim/gptmr_top_bench.sv
/* Self-checking bench for the timer pair.
   Assumes the checker is bound to the top. */
`timescale 1ns/1ps
module gptmr_top_bench
  import gptmr_pkg::*;
;
  logic clk, rst, pin, slp, adc, irq;
  gptmr_req_t req;
  logic [15:0] rdata, a, b;
  int n_fail = 0, n_checks = 0, n_adc = 0, n0;
  gptmr_top i_gptmr_top (.clock_i(clk), .rst_i(rst), .req_i(req),
    .gate_clock_input_pin_i(pin), .sleep_i(slp), .rdata_o(rdata),
    .adc_trigger_o(adc), .irq_o(irq));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tally of trigger pulses
  always @(posedge clk) begin
    if (adc === 1'b1) n_adc++;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Gap cycle after each strobe keeps one driver per step
  task wr(input logic [15:0] ad, input logic [15:0] d);
    req.addr <= ad;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task rd(input logic [15:0] ad, output logic [15:0] d);
    req.addr <= ad;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task t_regs;
    rd(OFF_LOW_PERIOD, a); chk(a, RST_PERIOD);
    rd(OFF_LOW_CTRL, a); chk(a, RST_CTRL);
    rd(16'h0120, a); chk(a, 16'h0000);
    wr(OFF_HIGH_CTRL, 16'hffff);
    rd(OFF_HIGH_CTRL, a); chk(a, HIGH_CTRL_MASK);
    wr(OFF_HIGH_CTRL, 16'h0000);
    // Upper timer alone, period 3: four matches in 18 counted cycles
    wr(OFF_HIGH_PERIOD, 16'h0003);
    wr(OFF_HIGH_COUNT, 16'h0000);
    n0 = n_adc;
    wr(OFF_HIGH_CTRL, 16'h8000);
    cyc(16);
    wr(OFF_HIGH_CTRL, 16'h0000);
    chk(16'(n_adc - n0), 16'h0004);
    $display("t_regs done");
  endtask : t_regs
  // Count gained over 512 cycles at each prescale code
  task t_div;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_LOW_CTRL, 16'h8000 | (16'(k) << BIT_PS_LO));
      rd(OFF_LOW_COUNT, a);
      cyc(510);
      rd(OFF_LOW_COUNT, b);
      chk(b - a, 16'(512 >> (3 * k - (k == 3))));
    end
    // Divide by 8; a count write mid-division restarts the prescaler
    wr(OFF_LOW_CTRL, 16'h8010);
    cyc(3);
    wr(OFF_LOW_COUNT, 16'h0000);
    cyc(6);
    rd(OFF_LOW_COUNT, a);
    chk(a, 16'h0000);
    rd(OFF_LOW_COUNT, a);
    chk(a, 16'h0001);
    wr(OFF_LOW_CTRL, 16'h0000);
    rd(OFF_LOW_COUNT, a);
    wr(OFF_LOW_CTRL, 16'h0030);
    rd(OFF_LOW_COUNT, b); chk(b, a);
    $display("t_div done");
  endtask : t_div
  task t_casc;
    wr(OFF_LOW_PERIOD, 16'h0003);
    wr(OFF_HIGH_PERIOD, 16'h0001);
    wr(OFF_LOW_CTRL, 16'h0008);
    wr(OFF_HOLD, 16'h0001);
    rd(OFF_HOLD, a); chk(a, 16'h0001);
    wr(OFF_LOW_COUNT, 16'h0000);
    rd(OFF_HIGH_COUNT, a); chk(a, 16'h0001);
    wr(OFF_IRQ_STATUS, 16'h0000);
    n0 = n_adc;
    // Upper control set up to divide, yet the cascade must ignore it
    wr(OFF_HIGH_CTRL, 16'h8030);
    wr(OFF_LOW_CTRL, 16'h8008);
    cyc(30);
    chk(16'(n_adc - n0), 16'h0001);
    rd(OFF_LOW_COUNT, a); chk({15'h0, a < 16'h0040}, 16'h0001);
    rd(OFF_HOLD, a); chk(a, 16'h0000);
    rd(OFF_HIGH_COUNT, a);
    chk(a, 16'h0000);
    rd(OFF_IRQ_STATUS, a); chk(a, 16'h0080);
    chk({15'h0, irq}, 16'h0000);
    wr(OFF_IRQ_ENABLE, 16'h0080);
    cyc(1); chk({15'h0, irq}, 16'h0001);
    rd(OFF_IRQ_STATUS, a); chk(a, 16'h0080);
    wr(OFF_IRQ_STATUS, 16'h0000);
    cyc(1); chk({15'h0, irq}, 16'h0000);
    wr(OFF_HIGH_CTRL, 16'h0000);
    wr(OFF_LOW_CTRL, 16'h0000);
    wr(OFF_IRQ_ENABLE, 16'h0000);
    $display("t_casc done");
  endtask : t_casc
  // Gate held high for 40 cycles, then for 20 cycles while asleep
  task t_gate;
    wr(OFF_LOW_PERIOD, RST_PERIOD);
    wr(OFF_LOW_CTRL, 16'h8040);
    wr(OFF_LOW_COUNT, 16'h0000);
    pin <= 1'b1; cyc(40);
    pin <= 1'b0; cyc(10);
    rd(OFF_LOW_COUNT, a); chk(a, 16'd40);
    cyc(20);
    rd(OFF_LOW_COUNT, a); chk(a, 16'd40);
    rd(OFF_IRQ_STATUS, a); chk(a, 16'h0080);
    slp <= 1'b1; cyc(5);
    pin <= 1'b1; cyc(20);
    pin <= 1'b0; cyc(10);
    slp <= 1'b0;
    rd(OFF_LOW_COUNT, a); chk(a, 16'd40);
    wr(OFF_LOW_CTRL, 16'h0000);
    $display("t_gate done");
  endtask : t_gate
  task wrap_up;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the few thousand cycles needed
  initial begin
    #200us;
    n_fail++;
    wrap_up;
  end
  initial begin
    rst = 1'b1; pin = 1'b0; slp = 1'b0; req = '0;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    t_regs; t_div; t_casc; t_gate;
    wrap_up;
  end
endmodule : gptmr_top_bench
